// ==== core/pli_pkg.sv ====
/*
 * shared constants, line codes, timing counts and state encoding for the
 * phy-side link interface controller.
 * assumes the core clock runs at 20 MHz (50 ns period).
 */
package pli_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;

  // control line codes, link owns the lines
  localparam logic [1:0] CTL_IDLE    = 2'h0;
  localparam logic [1:0] CTL_HOLD    = 2'h1;
  localparam logic [1:0] CTL_XMIT    = 2'h2;
  // control line codes, phy owns the lines
  localparam logic [1:0] CTL_STATUS  = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT   = 2'h3;

  localparam logic [7:0] DATA_ZERO    = 8'h00;
  localparam logic [7:0] DATA_ON_CODE = 8'hff;

  // power status timing, in ns as specified
  localparam int unsigned LPS_LOW_MAX_NS  = 2600;
  localparam int unsigned RESET_RECOG_NS  = 2680;
  localparam int unsigned DISABLE_MIN_NS  = 26030;
  localparam int unsigned DISABLE_MAX_NS  = 26110;
  localparam int unsigned CLK_ACT_MAX_NS  = 60;
  localparam int unsigned WAKE_MIN_NS     = 5300000;

  // longest legal low phase, rounded up; one more sample means deasserted
  localparam int unsigned LPS_LOW_MAX_CYC =
    (LPS_LOW_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_DETECT_CYC = LPS_LOW_MAX_CYC + 1;
  // the pin synchroniser and the state register add two cycles of latency,
  // so the count stops short to land inside the disable window
  localparam int unsigned MON_LAT_CYC = 2;
  localparam int unsigned DISABLE_DETECT_CYC =
    (DISABLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - MON_LAT_CYC;
  localparam int unsigned CLK_ACT_CYC =
    (CLK_ACT_MAX_NS / CLK_PERIOD_NS < 1) ? 1 : CLK_ACT_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC =
    (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // interface cycles of forced-low lines after power status returns
  localparam int unsigned INIT_LOW_CYC = 7;
  // consecutive idle samples that end link ownership
  localparam logic [1:0] LINK_END_IDLES = 2'h2;
  localparam logic [1:0] LINK_SKIP_CYC  = 2'h2;

  typedef enum logic [3:0] {
    ST_NORMAL   = 4'h0,
    ST_GRANT    = 4'h1,
    ST_HAND     = 4'h2,
    ST_LINK     = 4'h3,
    ST_GUARD    = 4'h4,
    ST_RESET    = 4'h5,
    ST_DISABLED = 4'h6,
    ST_WAKE     = 4'h7,
    ST_INIT_LOW = 4'h8,
    ST_INIT_RX  = 4'h9
  } pli_state_t;

endpackage : pli_pkg

// ==== core/pli_lps_mon.sv ====
/*
 * power status monitor: synchronises the power status pin and measures
 * how long it has been low, for pulsed or level signalling.
 * assumes one core clock; the pin is asynchronous to it.
 */
`timescale 1ns/1ns
module pli_lps_mon
  import pli_pkg::*;
#(
  parameter int unsigned CNT_W = 10
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic link_power_status,
  output logic      lps_level,
  output logic      reset_hit,
  output logic      disable_hit
);

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic [CNT_W-1:0] low_cnt;
  } pli_mon_t;

  localparam logic [CNT_W-1:0] RST_TH = CNT_W'(RESET_DETECT_CYC);
  localparam logic [CNT_W-1:0] DIS_TH = CNT_W'(DISABLE_DETECT_CYC);

  pli_mon_t r;
  pli_mon_t n;

  always_comb begin
    n    = r;
    n.s1 = link_power_status;
    n.s2 = r.s1;
    // a high sample restarts the count, so a pulsed signal never trips it
    if (r.s2) begin
      n.low_cnt = '0;
    end else if (r.low_cnt < DIS_TH) begin
      n.low_cnt = r.low_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lps_level   = r.s2;
  assign reset_hit   = (r.low_cnt >= RST_TH);
  assign disable_hit = (r.low_cnt >= DIS_TH);

endmodule : pli_lps_mon

// ==== core/pli_iface_ctrl.sv ====
/*
 * phy-side controller of the parallel link interface: grant handover and
 * return, interface reset, disable, low power wake and initialization.
 * assumes an external gate makes the interface clock from iface_clk_run,
 * and that the testbench resolves the shared lines from the enables.
 */
// Summary of operation
// - link-owned control codes are idle 00, hold 01, transmit 10.
// - phy grants with code 11 for one cycle, then one idle cycle.
// - phy drives at least one idle after taking lines back.
// - when not operational, drop pending requests, ignore request line.
// - status arising while not operational is discarded for good.
// - phy detects deasserted power status about 2.78 us after it falls (2.68 us required) and resets.
// - in reset phy drives lines to zero and ignores requests.
// - low 26.03-26.11 us disables interface and stops the clock low.
// - hardware reset leaves the interface disabled.
// - disabled with no active port puts phy into low power.
// - clock restarts within 60 ns (here up to 150 ns after the pin rises), or 5.3-7.3 ms from low power.
// - restored clock is a 49.152 MHz square wave (here the lines are registered on the 20 MHz core clock).
// - phy holds lines low for the first 7 cycles after return.
// - eighth cycle drives receive and all-ones data for one cycle.
// - idle and zero data end initialization; requests then accepted.
`timescale 1ns/1ns
module pli_iface_ctrl
  import pli_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned CNT_W       = 17
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       link_power_status,
  input  wire logic       link_request_line,
  input  wire logic [1:0] ctl_i,
  output logic      [1:0] ctl_o,
  output logic            ctl_oe,
  output logic      [7:0] data_o,
  output logic            data_oe,
  output logic            iface_clk_run,
  output logic            low_power,
  input  wire logic       ports_active,
  input  wire logic       grant_req,
  output logic            grant_ack,
  input  wire logic       out_valid,
  input  wire logic [1:0] out_ctl,
  input  wire logic [7:0] out_data,
  output logic            out_ready,
  output logic            link_req_out,
  output logic            req_cancel,
  output logic            iface_op
);

  typedef struct packed {
    pli_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       idle_cnt;
    logic             link_request_line_s1;
    logic             link_request_line_s2;
    logic [1:0]       ctl_s1;
    logic [1:0]       ctl_s2;
    logic [1:0]       ctl_o;
    logic [7:0]       data_o;
    logic             oe;
    logic             clk_run;
    logic             lowp;
    logic             req_out;
    logic             cancel;
    logic             gack;
  } pli_ctrl_t;

  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_LOW_CYC - 1);

  function automatic logic is_op(input pli_state_t s);
    is_op = (s == ST_NORMAL) || (s == ST_GRANT) || (s == ST_HAND) ||
            (s == ST_LINK) || (s == ST_GUARD);
  endfunction : is_op

  pli_ctrl_t r;
  pli_ctrl_t n;
  logic      lps_level;
  logic      reset_hit;
  logic      disable_hit;

  pli_lps_mon #(
    .CNT_W (10)
  ) u_lps_mon (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .link_power_status (link_power_status),
    .lps_level         (lps_level),
    .reset_hit         (reset_hit),
    .disable_hit       (disable_hit)
  );

  always_comb begin
    n         = r;
    n.link_request_line_s1 = link_request_line;
    n.link_request_line_s2 = r.link_request_line_s1;
    n.ctl_s1  = ctl_i;
    n.ctl_s2  = r.ctl_s1;
    n.ctl_o   = CTL_IDLE;
    n.data_o  = DATA_ZERO;
    n.oe      = 1'b1;
    n.gack    = 1'b0;
    case (r.st)
      ST_NORMAL: begin
        if (out_valid) begin
          n.ctl_o  = out_ctl;
          n.data_o = out_data;
        end else if (grant_req) begin
          n.st    = ST_GRANT;
          n.ctl_o = CTL_GRANT;
          n.gack  = 1'b1;
        end
      end
      ST_GRANT: begin
        n.st = ST_HAND;
      end
      ST_HAND: begin
        n.st       = ST_LINK;
        n.oe       = 1'b0;
        n.cnt      = '0;
        n.idle_cnt = 2'h0;
      end
      ST_LINK: begin
        n.oe = 1'b0;
        // the first two samples still show our own grant and idle
        if (r.cnt < CNT_W'(LINK_SKIP_CYC)) begin
          n.cnt = r.cnt + 1'b1;
        end else if (r.ctl_s2 == CTL_IDLE) begin
          n.idle_cnt = r.idle_cnt + 2'h1;
          if (r.idle_cnt + 2'h1 == LINK_END_IDLES) begin
            n.st = ST_GUARD;
            n.oe = 1'b1;
          end
        end else begin
          n.idle_cnt = 2'h0;
        end
      end
      ST_GUARD: begin
        n.st = ST_NORMAL;
      end
      ST_RESET: begin
        if (disable_hit) begin
          n.st      = ST_DISABLED;
          n.clk_run = 1'b0;
        end else if (lps_level) begin
          n.st  = ST_INIT_LOW;
          n.cnt = '0;
        end
      end
      ST_DISABLED: begin
        n.clk_run = 1'b0;
        n.lowp    = !ports_active;
        if (lps_level) begin
          n.cnt = '0;
          if (r.lowp) begin
            n.st = ST_WAKE;
          end else begin
            n.st      = ST_INIT_LOW;
            n.clk_run = 1'b1;
          end
        end
      end
      ST_WAKE: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == WAKE_LAST) begin
          n.st      = ST_INIT_LOW;
          n.cnt     = '0;
          n.clk_run = 1'b1;
          n.lowp    = 1'b0;
        end
      end
      ST_INIT_LOW: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == INIT_LAST) begin
          n.st     = ST_INIT_RX;
          n.ctl_o  = CTL_RECEIVE;
          n.data_o = DATA_ON_CODE;
        end
      end
      ST_INIT_RX: begin
        n.st = ST_NORMAL;
      end
      default: begin
        n.st      = ST_DISABLED;
        n.clk_run = 1'b0;
      end
    endcase
    // deassertion overrides everything while the clock still runs
    if (reset_hit && (is_op(r.st) || r.st == ST_INIT_LOW ||
                      r.st == ST_INIT_RX)) begin
      n.st     = ST_RESET;
      n.ctl_o  = CTL_IDLE;
      n.data_o = DATA_ZERO;
      n.oe     = 1'b1;
      n.gack   = 1'b0;
    end
    n.req_out = is_op(n.st) && r.link_request_line_s2;
    n.cancel  = is_op(r.st) && !is_op(n.st);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r    <= '0;
      r.st <= ST_DISABLED;
      r.oe <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign ctl_o         = r.ctl_o;
  assign data_o        = r.data_o;
  assign ctl_oe        = r.oe;
  assign data_oe       = r.oe;
  assign iface_clk_run = r.clk_run;
  assign low_power     = r.lowp;
  assign grant_ack     = r.gack;
  assign link_req_out  = r.req_out;
  assign req_cancel    = r.cancel;
  assign iface_op      = is_op(r.st);
  // words offered while not operational are swallowed, never replayed
  assign out_ready     = !is_op(r.st) ||
                         (r.st == ST_NORMAL && !reset_hit);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_grant;
    ctl_o == CTL_GRANT && ctl_oe;
  endsequence
  sequence s_init_low;
    (ctl_o == CTL_IDLE && data_o == DATA_ZERO && ctl_oe)[*7];
  endsequence
  sequence s_init_rx;
    ctl_o == CTL_RECEIVE && data_o == DATA_ON_CODE && ctl_oe;
  endsequence
  sequence s_init_done;
    ctl_o == CTL_IDLE && data_o == DATA_ZERO && iface_op;
  endsequence

  grant_idle_a: assert property (
    (s_grant and !reset_hit) |=> ctl_o == CTL_IDLE && ctl_oe)
    else $error("grant not followed by an idle cycle");
  hand_release_a: assert property (
    r.st == ST_HAND && !reset_hit |=> !ctl_oe && !data_oe)
    else $error("lines not released after handover idle");
  guard_idle_a: assert property (
    $rose(ctl_oe) && iface_op |-> ctl_o == CTL_IDLE &&
    data_o == DATA_ZERO ##1 r.st == ST_NORMAL)
    else $error("no idle guard cycle after taking lines back");
  reset_zero_a: assert property (
    reset_hit && iface_op |=>
    (ctl_o == CTL_IDLE && data_o == DATA_ZERO && ctl_oe && !iface_op)[*2])
    else $error("reset did not drive the lines low");
  req_gate_a: assert property (
    !iface_op |-> !link_req_out)
    else $error("request passed while interface not operational");
  req_cancel_a: assert property (
    $fell(iface_op) |-> req_cancel)
    else $error("pending request not cancelled on leaving operation");
  status_drop_a: assert property (
    out_valid && !iface_op |-> out_ready ##1 ctl_o != CTL_STATUS)
    else $error("status not discarded while not operational");
  init_seq_a: assert property (
    $rose(r.st == ST_INIT_LOW) |-> s_init_low ##1 s_init_rx ##1 s_init_done)
    else $error("initialization sequence out of order");
  disable_clk_a: assert property (
    r.st == ST_RESET && disable_hit |=> r.st == ST_DISABLED && !iface_clk_run)
    else $error("interface not disabled after long deassertion");
  low_power_a: assert property (
    r.st == ST_DISABLED && !ports_active && !lps_level |=> low_power)
    else $error("no low power while disabled and ports idle");
  clk_restart_a: assert property (
    r.st == ST_DISABLED && lps_level && !low_power |=> iface_clk_run)
    else $error("interface clock not restarted within one cycle");
  wake_wait_a: assert property (
    r.st == ST_DISABLED && lps_level && low_power |=> !iface_clk_run)
    else $error("clock restarted without low power wake wait");

endmodule : pli_iface_ctrl

// ==== test/pli_link_model.sv ====
/* link-side model of the shared control lines: resolves the wire from
   both enables and plays a cancelled transmission after a grant.
   assumes the phy outputs are registered on core_clk. */
`timescale 1ns/1ns
module pli_link_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] ctl_o,
  input  wire logic       ctl_oe,
  output logic      [1:0] ctl_wire
);
  import pli_pkg::*;
  logic       drv_en  = 1'b0;
  logic [1:0] drv_val = 2'h0;
  logic [1:0] last    = 2'h0;
  // a released wire must not keep showing a plausible stale code
  assign ctl_wire = ctl_oe ? ctl_o : (drv_en ? drv_val : ~last);
  always @(posedge core_clk) last <= ctl_wire;

  task automatic drive(input logic [1:0] v);
    @(negedge core_clk);
    drv_en  <= 1'b1;
    drv_val <= v;
  endtask : drive

  task automatic cancel(input bit lead, input int nhold);
    while (!(ctl_oe && ctl_o === CTL_GRANT)) @(negedge core_clk);
    // let the handover idle pass before taking the lines
    @(negedge core_clk);
    // with no holds the lead idle and the first closing idle make the two-idle cancel
    if (lead) drive(CTL_IDLE);
    repeat (nhold) drive(CTL_HOLD);
    drive(CTL_IDLE);
    drive(CTL_IDLE);
    @(negedge core_clk);
    drv_en <= 1'b0;
  endtask : cancel
endmodule : pli_link_model

// ==== test/test_phy_link_iface_reset_control.sv ====
/* self-checking bench for the phy-side interface controller.
   assumes a 20 MHz core clock and a shortened low-power wake count. */
`timescale 1ns/1ns
module test_phy_link_iface_reset_control;
  import pli_pkg::*;
  localparam int WAKE = 20;
  logic core_clk = 1'b0, rstn = 1'b0, pwr = 1'b0, req_ln = 1'b0;
  logic ports_active = 1'b0, grant_req = 1'b0, out_valid = 1'b0;
  logic [1:0] out_ctl = 2'h0, ctl_o, ctl_wire;
  logic [7:0] out_data = 8'h00, data_o;
  logic ctl_oe, data_oe, iface_clk_run, low_power, grant_ack;
  logic out_ready, link_req_out, req_cancel, iface_op;
  int fails = 0, total_checks = 0;

  always #25 core_clk = ~core_clk;

  pli_iface_ctrl #(.WAKE_CYCLES(WAKE)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .link_power_status(pwr),
    .link_request_line(req_ln), .ctl_i(ctl_wire), .ctl_o(ctl_o),
    .ctl_oe(ctl_oe), .data_o(data_o), .data_oe(data_oe),
    .iface_clk_run(iface_clk_run), .low_power(low_power),
    .ports_active(ports_active), .grant_req(grant_req),
    .grant_ack(grant_ack), .out_valid(out_valid), .out_ctl(out_ctl),
    .out_data(out_data), .out_ready(out_ready),
    .link_req_out(link_req_out), .req_cancel(req_cancel),
    .iface_op(iface_op));
  pli_link_model link_u (.core_clk(core_clk), .ctl_o(ctl_o),
    .ctl_oe(ctl_oe), .ctl_wire(ctl_wire));

  task automatic chk(input logic [7:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // lines stay low until the receive code, then idle ends the sequence
  task automatic init_walk(input bit exact);
    int n = 0;
    req_ln = 1'b0;
    for (int i = 0; i < 60 && ctl_o !== CTL_RECEIVE; i++) begin
      if (iface_clk_run === 1'b1) n++;
      chk({6'h0, |ctl_o, |data_o}, 8'h00, "init low");
      chk(link_req_out, 0, "init req");
      cyc(1);
    end
    chk(exact ? n == 7 : n >= 7, 1, "init len");
    chk(ctl_o, CTL_RECEIVE, "rx code");
    chk(data_o, DATA_ON_CODE, "data on");
    cyc(1);
    chk(ctl_o, CTL_IDLE, "init idle");
    chk(data_o, DATA_ZERO, "init zero");
    chk(iface_op, 1, "op");
  endtask : init_walk

  task automatic t_hw();
    chk(iface_clk_run, 0, "hw clk");
    chk({6'h0, ctl_o} | data_o, 0, "hw lines");
    chk(iface_op, 0, "hw op");
    chk(low_power, 1, "low pwr");
    $display("hw reset done");
  endtask : t_hw

  task automatic t_wake();
    int n;
    pwr = 1'b1;
    for (n = 0; n < 40 && iface_clk_run !== 1'b1; n++) cyc(1);
    chk(n >= WAKE && n <= WAKE + 4, 1, "wake");
    init_walk(1);
    req_ln = 1'b1;
    cyc(3);
    chk(link_req_out, 1, "req fwd");
    req_ln = 1'b0;
    $display("wake done");
  endtask : t_wake

  task automatic t_grant(input bit lead, input int nhold);
    int n, s;
    s = nhold > 0 ? lead + nhold : 0;
    grant_req = 1'b1;
    fork link_u.cancel(lead, nhold); join_none
    for (n = 0; n < 20 && grant_ack !== 1'b1; n++) cyc(1);
    chk({grant_ack, ctl_oe, ctl_o}, {2'b11, CTL_GRANT}, "grant");
    grant_req = 1'b0;
    cyc(1);
    chk({grant_ack, ctl_oe, ctl_o}, {2'b01, CTL_IDLE},
        "hand idle");
    out_valid = 1'b1;
    out_ctl = CTL_STATUS;
    out_data = 8'h5a;
    cyc(1);
    chk({out_ready, ctl_oe, data_oe}, 0, "busy");
    for (n = 0; n < 80 && ctl_oe !== 1'b1; n++) cyc(1);
    chk(n, s + 4, "own len");
    chk(ctl_o, CTL_IDLE, "guard");
    for (n = 0; n < 4 && ctl_o !== CTL_STATUS; n++) cyc(1);
    chk(data_o, 8'h5a, "status");
    out_valid = 1'b0;
    cyc(3);
    $display("grant %0d %0d done", lead, nhold);
  endtask : t_grant

  task automatic t_reset();
    int n;
    bit seen = 0;
    repeat (3) begin
      pwr = 1'b0;
      cyc(40);
      pwr = 1'b1;
      cyc(30);
      chk(iface_op, 1, "pulsed");
    end
    pwr = 1'b0;
    for (n = 0; n < 70 && iface_op !== 1'b0; n++) begin
      seen |= req_cancel === 1'b1;
      cyc(1);
    end
    // the cancel pulse stands in the first non-operational cycle
    seen |= req_cancel === 1'b1;
    chk(n >= 52 && n <= 57, 1, "rst time");
    chk(seen, 1, "cancel");
    chk({ctl_oe, ctl_o} | data_o, 8'h04, "rst lines");
    req_ln = 1'b1;
    out_valid = 1'b1;
    out_data = 8'ha5;
    cyc(1);
    chk(out_ready, 1, "drop");
    out_valid = 1'b0;
    cyc(3);
    chk(link_req_out, 0, "req off");
    req_ln = 1'b0;
    chk(iface_clk_run, 1, "rst clk");
    cyc(260);
    pwr = 1'b1;
    init_walk(0);
    cyc(3);
    chk(ctl_o, CTL_IDLE, "no stale");
    $display("reset done");
  endtask : t_reset

  task automatic t_disable();
    int n;
    ports_active = 1'b1;
    pwr = 1'b0;
    for (n = 0; n < 600 && iface_clk_run !== 1'b0; n++) cyc(1);
    chk(n * CLK_PERIOD_NS >= DISABLE_MIN_NS &&
        (n - 1) * CLK_PERIOD_NS < DISABLE_MAX_NS, 1, "dis time");
    chk(low_power, 0, "active");
    chk({ctl_oe, ctl_o} | data_o, 8'h04, "dis lines");
    cyc(4);
    pwr = 1'b1;
    for (n = 0; n < 10 && iface_clk_run !== 1'b1; n++) cyc(1);
    chk(n <= 3, 1, "restart");
    init_walk(1);
    $display("disable done");
  endtask : t_disable

  initial begin
    cyc(2);
    rstn = 1'b1;
    cyc(2);
    t_hw();
    t_wake();
    t_grant(1, 0);
    t_grant(0, 47);
    t_grant(1, 2);
    t_reset();
    t_disable();
    test_done();
  end

  initial begin
    repeat (12000) @(posedge core_clk);
    fails++;
    test_done();
  end
endmodule : test_phy_link_iface_reset_control
